// *** src/dcf_defines.vh ***
// Purpose: Shared constants for the dual configurable-clock flip-flop block.
// Assumes: Included by bare name from every design file.
// Notes:   Definitions only.
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH

// ****************************************************************
// Structure
// ****************************************************************
`define DCF_CHANNELS      2
`define DCF_PIN_BITS      12

// ****************************************************************
// Reset values
// ****************************************************************
`define DCF_BIT_RESET     1'h0
`define DCF_BIT_SET       1'h1
`define DCF_PAIR_RESET    2'h0
// Synchroniser order is data, clear, selects A to D; the clear pins
// reset high so that leaving reset is not read as a clear.
`define DCF_PINS_RESET    12'h300

// ****************************************************************
// Start-up priming
// ****************************************************************
// Two synchroniser stages plus the clock register must fill before the
// edge detector holds a real earlier sample to compare against.
`define DCF_PRIME_BITS    2
`define DCF_PRIME_RESET   2'h0
`define DCF_PRIME_STEP    2'h1
`define DCF_PRIME_DONE    2'h3

`endif

// *** src/dcf_sync2.v ***
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clock.
// Notes:   Stage one feeds only stage two.
`timescale 1ns/1ps
`include "dcf_defines.vh"

module dcf_sync2 (
    clock,
    rst,
    clk_en,
    pin_in,
    pin_sync
);
    input  wire                        clock;
    input  wire                        rst;
    input  wire                        clk_en;
    input  wire [`DCF_PIN_BITS-1:0]    pin_in;
    output wire [`DCF_PIN_BITS-1:0]    pin_sync;

    reg         [`DCF_PIN_BITS-1:0]    meta_q;
    reg         [`DCF_PIN_BITS-1:0]    sync_q;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= `DCF_PINS_RESET;
            sync_q <= `DCF_PINS_RESET;
        end else if (clk_en) begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;
endmodule // dcf_sync2

// *** src/dcf_dual_flop.v ***
// Purpose: Two independent D flip-flops, each clocked by a configurable
//          four-input logic function of its own clock-select pins.
// Assumes: All pins come from outside the clock domain.
// Notes:   Pin edges are seen on the sampled system clock.
`timescale 1ns/1ps
`include "dcf_defines.vh"

module dcf_dual_flop (
    clock,
    rst,
    clk_en,
    data_in,
    async_clear_n,
    clock_select_a,
    clock_select_b,
    clock_select_c,
    clock_select_d,
    q_out,
    q_known,
    internal_clock
);
    input  wire [0:0]                  clock;
    input  wire                        rst;
    input  wire                        clk_en;
    input  wire [`DCF_CHANNELS-1:0]    data_in;
    input  wire [`DCF_CHANNELS-1:0]    async_clear_n;
    input  wire [`DCF_CHANNELS-1:0]    clock_select_a;
    input  wire [`DCF_CHANNELS-1:0]    clock_select_b;
    input  wire [`DCF_CHANNELS-1:0]    clock_select_c;
    input  wire [`DCF_CHANNELS-1:0]    clock_select_d;
    output wire [`DCF_CHANNELS-1:0]    q_out;
    output wire [`DCF_CHANNELS-1:0]    q_known;
    output wire [`DCF_CHANNELS-1:0]    internal_clock;

    // ****************************************************************
    // Configurable clock function
    // ****************************************************************
    // Select A chooses the gate of B and C; select D sets its polarity.
    function cfg_clock;
        input sel_a;
        input sel_b;
        input sel_c;
        input sel_d;
        reg   gate;
        begin
            gate = sel_a ? (sel_b | ~sel_c) : (sel_b & sel_c);
            cfg_clock = sel_d ^ gate;
        end
    endfunction

    // ****************************************************************
    // Channel helpers
    // ****************************************************************
    // A rise counts only once the detector holds a real earlier sample.
    function edge_rise;
        input prev_y;
        input now_y;
        input armed;
        begin
            edge_rise = armed & ~prev_y & now_y;
        end
    endfunction

    // Clear beats a rise in the same cycle; a rise loads the data pin.
    function next_q;
        input clear_n;
        input rise_now;
        input data;
        input held;
        begin
            if (!clear_n) begin
                next_q = `DCF_BIT_RESET;
            end else if (rise_now) begin
                next_q = data;
            end else begin
                next_q = held;
            end
        end
    endfunction

    // The output becomes defined at its first clear or capture.
    function next_known;
        input clear_n;
        input rise_now;
        input known;
        begin
            if (!clear_n || rise_now) begin
                next_known = `DCF_BIT_SET;
            end else begin
                next_known = known;
            end
        end
    endfunction

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    // Pins are packed data, clear, then selects A to D, two bits each.
    // The clear pins leave reset high, so reset is never read as a clear.
    wire [`DCF_PIN_BITS-1:0]  pins_sync;
    wire [`DCF_CHANNELS-1:0]  data_s;
    wire [`DCF_CHANNELS-1:0]  clear_n_s;
    wire [`DCF_CHANNELS-1:0]  sel_a_s;
    wire [`DCF_CHANNELS-1:0]  sel_b_s;
    wire [`DCF_CHANNELS-1:0]  sel_c_s;
    wire [`DCF_CHANNELS-1:0]  sel_d_s;

    dcf_sync2 u_sync (
        .clock    (clock),
        .rst      (rst),
        .clk_en   (clk_en),
        .pin_in   ({data_in,
                    async_clear_n,
                    clock_select_a,
                    clock_select_b,
                    clock_select_c,
                    clock_select_d}),
        .pin_sync (pins_sync)
    );

    assign {data_s, clear_n_s,
            sel_a_s, sel_b_s,
            sel_c_s, sel_d_s} = pins_sync;

    // ****************************************************************
    // Start-up priming
    // ****************************************************************
    // Until the synchroniser and the clock register have filled with real
    // pin samples, the earlier clock sample is a reset value, and a clock
    // that is already high must not be taken as a rise.
    reg  [`DCF_PRIME_BITS-1:0]  prime_q;
    reg  [`DCF_PRIME_BITS-1:0]  prime_d;
    wire                        primed;

    assign primed = (prime_q == `DCF_PRIME_DONE);

    always @* begin
        if (primed) begin
            prime_d = prime_q;
        end else begin
            prime_d = prime_q + `DCF_PRIME_STEP;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            prime_q <= `DCF_PRIME_RESET;
        end else if (clk_en) begin
            prime_q <= prime_d;
        end
    end

    // ****************************************************************
    // Per-channel flip-flops
    // ****************************************************************
    // Each channel is its own generate block and reads only its own bit.
    wire [`DCF_CHANNELS-1:0]  y_vec;
    wire [`DCF_CHANNELS-1:0]  q_vec;
    wire [`DCF_CHANNELS-1:0]  known_vec;
    genvar                    ch;

    generate
        for (ch = 0; ch < `DCF_CHANNELS; ch = ch + 1) begin : g_ch
            reg   y_q;
            reg   y_d;
            reg   q_q;
            reg   q_d;
            reg   known_q;
            reg   known_d;
            wire  rise;

            // Y is registered so that the edge detector sees settled samples.
            always @* begin
                y_d = cfg_clock(sel_a_s[ch], sel_b_s[ch],
                                sel_c_s[ch], sel_d_s[ch]);
            end

            assign rise = edge_rise(y_q, y_d, primed);

            always @* begin
                q_d     = next_q(clear_n_s[ch], rise,
                                 data_s[ch], q_q);
                known_d = next_known(clear_n_s[ch], rise,
                                     known_q);
            end

            // Clock enable low freezes every register of the channel.
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    y_q     <= `DCF_BIT_RESET;
                    q_q     <= `DCF_BIT_RESET;
                    known_q <= `DCF_BIT_RESET;
                end else if (clk_en) begin
                    y_q     <= y_d;
                    q_q     <= q_d;
                    known_q <= known_d;
                end
            end

            assign y_vec[ch]     = y_q;
            assign q_vec[ch]     = q_q;
            assign known_vec[ch] = known_q;
        end
    endgenerate

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // All three outputs come straight from flip-flops, so they change
    // only on a rising edge of the system clock or of rst.
    assign q_out          = q_vec;
    assign q_known        = known_vec;
    assign internal_clock = y_vec;
endmodule // dcf_dual_flop

// *** testbench/dcf_asserts.sv ***
// Purpose: Port checks for dcf_dual_flop.
// Assumes: pins reach outputs three enabled edges later.
// Notes:   Bound below.
`timescale 1ns/1ps
module dcf_chk (
    input wire [0:0] clock,
    input wire       rst,
    input wire       clk_en,
    input wire [1:0] data_in,
    input wire [1:0] async_clear_n,
    input wire [1:0] clock_select_a,
    input wire [1:0] clock_select_b,
    input wire [1:0] clock_select_c,
    input wire [1:0] clock_select_d,
    input wire [1:0] q_out,
    input wire [1:0] q_known,
    input wire [1:0] internal_clock
);
    wire [1:0] y_w = clock_select_d ^ (clock_select_a & (clock_select_b
        | ~clock_select_c) | ~clock_select_a & clock_select_b & clock_select_c);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_run;
        !$past(rst, 5) && $past(clk_en) && $past(clk_en, 2)
        && $past(clk_en, 3);
    endsequence
    a_y_func: assert property (s_run |->
        internal_clock == $past(y_w, 3)) else $error("bad y");
    a_clear_low: assert property (s_run |->
        (~$past(async_clear_n, 3) & q_out) == 2'h0) else $error("bad clear");
    a_rise_load: assert property (s_run |->
        (internal_clock & ~$past(internal_clock) & $past(async_clear_n, 3)
        & (q_out ^ $past(data_in, 3))) == 2'h0) else $error("bad load");
    a_q_hold: assert property (s_run |->
        (~(internal_clock & ~$past(internal_clock)) & $past(async_clear_n, 3)
        & (q_out ^ $past(q_out))) == 2'h0) else $error("bad hold");
    a_known_set: assert property (s_run |-> q_known ==
        ($past(q_known) | ~$past(async_clear_n, 3) | internal_clock
        & ~$past(internal_clock))) else $error("bad known");
    a_unknown_zero: assert property ((q_out & ~q_known) == 2'h0)
        else $error("q set while unknown");
    a_reset_zero: assert property (disable iff (1'b0) rst |->
        {q_out, q_known, internal_clock} == 6'h00) else $error("bad reset");
    a_en_freeze: assert property (!clk_en |=>
        $stable({q_out, q_known, internal_clock}))
        else $error("moved while frozen");
endmodule // dcf_chk
bind dcf_dual_flop dcf_chk chk_u (.clock, .rst, .clk_en, .data_in,
    .async_clear_n,
    .clock_select_a, .clock_select_b, .clock_select_c, .clock_select_d,
    .q_out, .q_known, .internal_clock);

// *** testbench/dcf_pins.sv ***
// Purpose: Outside logic driving the pins.
// Assumes: Pins change on falling edges.
// Notes:   Packed as clear_n, data, select a to d.
`timescale 1ns/1ps
module dcf_pins (
    input  wire        clock,
    output reg  [11:0] pins_q = 12'hc00
);
    task put(input [11:0] v);
        @(negedge clock) pins_q = v;
    endtask
endmodule // dcf_pins

// *** testbench/tb.sv ***
// Purpose: Random pin steps against a reference model.
// Assumes: Data moves before the selects that could raise the clock.
// Notes:   A watcher pops notes when due.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
    reg         clock = 1'b0;
    reg         rst = 1'b0;
    reg         clk_en = 1'b1;
    wire [11:0] p;
    wire [5:0]  o;
    int         err_count, n_compared, cyc, i, due[$];
    reg  [5:0]  m, e, note[$];
    reg  [1:0]  y;
    reg  [11:0] v;
    always #4 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    dcf_pins pm_u (.clock(clock), .pins_q(p));
    dcf_dual_flop dut_u (.clock(clock), .rst(rst), .clk_en(clk_en),
        .data_in(p[9:8]), .async_clear_n(p[11:10]), .clock_select_a(p[7:6]),
        .clock_select_b(p[5:4]), .clock_select_c(p[3:2]),
        .clock_select_d(p[1:0]), .q_out(o[3:2]), .q_known(o[5:4]),
        .internal_clock(o[1:0]));
    task tally_and_finish;
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Reference model m holds known, q and internal clock per channel.
    task step(input [11:0] s);
        begin
            y = s[1:0] ^ (s[7:6] & (s[5:4] | ~s[3:2])
                | ~s[7:6] & s[5:4] & s[3:2]);
            m[5:4] = m[5:4] | ~s[11:10] | y & ~m[1:0];
            m[3:2] = s[11:10] & (y & ~m[1:0] & s[9:8]
                | ~(y & ~m[1:0]) & m[3:2]);
            m[1:0] = y;
            pm_u.put(s);
            due.push_back(cyc + 4);
            note.push_back(m);
            repeat (6) @(negedge clock);
        end
    endtask
    always @(negedge clock) if (due.size() > 0 && cyc == due[0]) begin
        void'(due.pop_front());
        e = note.pop_front();
        `CHK("outs", e, o)
    end
    always @(posedge clock) if (cyc == 3000) begin
        err_count++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(35764));
        m = 6'h00;
        #1 rst = 1'b1;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        step(12'hc00);
        step(12'h000);
        for (i = 0; i < 96; i++) begin
            v = $urandom;
            v[11:10] = v[11:10] | v[7:6];
            {v[7], v[5], v[3], v[1]} = i[3:0];
            step({v[11:8], p[7:0]});
            step(v);
            // Frozen by clock enable, inverted pins must not move outputs.
            if (i == 24) begin
                clk_en = 1'b0;
                pm_u.put(~v);
                due.push_back(cyc + 4);
                note.push_back(m);
                repeat (6) @(negedge clock);
                pm_u.put(v);
                clk_en = 1'b1;
            end
            if (i == 48) begin
                step(12'hc00);
                rst = 1'b1;
                repeat (16) @(negedge clock);
                rst = 1'b0;
                m = 6'h00;
            end
        end
        tally_and_finish;
    end
endmodule // tb
